// File: core/dee_pkg.sv
// Constants, offsets and types shared by the data store access block.
// Assumes a 50 MHz core clock and a 32-bit classic Wishbone register bus.
package dee_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_ACCESS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_UNLOCK_PORT = 8'h04;
  localparam logic [7:0] OFS_CELL_POINTER = 8'h08;
  localparam logic [7:0] OFS_CELL_VALUE = 8'h0C;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h10;
  // Access control fields
  localparam int BIT_READ_STROBE = 0;
  localparam int BIT_WRITE_STROBE = 1;
  localparam int BIT_STORE_ARM = 2;
  localparam int BIT_ABORTED = 3;
  localparam int BIT_CONFIG_SEL = 6;
  localparam int BIT_CODE_SEL = 7;
  // Event status fields
  localparam int BIT_DONE_FLAG = 0;
  localparam int BIT_POWERUP_BUSY = 1;
  // Unlock keys
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
  // Reset values
  localparam logic [7:0] CELL_ERASED = 8'hFF;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Timing
  localparam int unsigned CLOCK_MHZ = 50;
  localparam int unsigned STORE_TIME_US = 4;
  localparam int unsigned STORE_CYCLES = STORE_TIME_US * CLOCK_MHZ;
  localparam int unsigned POWERUP_TIME_MS = 72;
  localparam int unsigned POWERUP_CYCLES = POWERUP_TIME_MS * CLOCK_MHZ * 1000;
  localparam int unsigned STORE_CNT_W = 8;
  localparam int unsigned POWERUP_CNT_W = 22;
  // Unlock sequence states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_GOT_FIRST = 3'b010,
    SEQ_OPEN = 3'b100
  } dee_seq_e;
endpackage

// File: core/dee_cell_array.sv
// Byte-wide nonvolatile cell array modelled in flip-flops.
// Assumes one write port and one combinational read port on the same clock.
`timescale 1ns/100ps
module dee_cell_array
  import dee_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic write_en,
  input wire logic [7:0] write_index,
  input wire logic [7:0] write_value,
  input wire logic [7:0] read_index,
  output logic [7:0] read_value
);
  logic [7:0] cell_r [256];

  // Power-on only; an erased array reads as all ones
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) begin
        cell_r[i] <= CELL_ERASED;
      end
    end else if (write_en) begin
      cell_r[write_index] <= write_value;
    end
  end

  assign read_value = cell_r[read_index];
endmodule

// File: core/dee_down_timer.sv
// Self-timed interval counter: busy for COUNT cycles, then a done pulse.
// Assumes start is ignored while busy; abort ends the interval with no pulse.
`timescale 1ns/100ps
module dee_down_timer #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned COUNT = 1,
  parameter bit START_RUNNING = 1'b0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);
  localparam logic [WIDTH-1:0] LAST = WIDTH'(COUNT - 1);
  localparam logic [WIDTH-1:0] START_CNT = START_RUNNING ? LAST : '0;
  logic [WIDTH-1:0] count_r;
  logic busy_r;
  logic done_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= START_CNT;
      busy_r <= START_RUNNING;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (abort) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        if (count_r == '0) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          count_r <= count_r - 1'b1;
        end
      end else if (start) begin
        busy_r <= 1'b1;
        count_r <= LAST;
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;
endmodule

// File: core/dee_access_ctrl.sv
// Data store access control: pointer, value, unlock gate and timed writes.
// Assumes a classic Wishbone master on clock; reset pins arrive unsynchronised.
`timescale 1ns/100ps
module dee_access_ctrl
  import dee_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES_P = POWERUP_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic master_clear_pin_n,
  input wire logic watchdog_reset
);
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  logic ack_r;
  logic [31:0] rdata_r;
  logic [1:0] master_clear_pin_sync_r;
  logic [1:0] wdt_sync_r;
  logic warm_rst;
  logic req;
  logic wr;
  logic rd;
  logic [7:0] key;
  logic ctrl_wr;
  logic unlock_wr;
  dee_seq_e seq_r;
  dee_seq_e seq_nxt;
  logic code_sel_r;
  logic config_sel_r;
  logic arm_r;
  logic aborted_r;
  logic read_strobe_r;
  logic done_flag_r;
  logic [7:0] pointer_r;
  logic [7:0] value_r;
  logic [7:0] store_addr_r;
  logic [7:0] store_data_r;
  logic store_busy;
  logic store_done;
  logic powerup_busy;
  logic start_store;
  logic [7:0] mem_rdata;
  logic [7:0] ctrl_view;

  // Two-stage synchronisers for the external reset sources
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_pin_sync_r <= 2'h3;
      wdt_sync_r <= 2'h0;
    end else begin
      master_clear_pin_sync_r <= {master_clear_pin_sync_r[0], master_clear_pin_n};
      wdt_sync_r <= {wdt_sync_r[0], watchdog_reset};
    end
  end

  assign warm_rst = !master_clear_pin_sync_r[1] || wdt_sync_r[1];

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;
  assign key = wb_dat_i[7:0];
  assign ctrl_wr = wr && hit(wb_adr_i, OFS_ACCESS_CONTROL);
  assign unlock_wr = wr && hit(wb_adr_i, OFS_UNLOCK_PORT);

  // Arm must already be set from an earlier write, selects point at data
  assign start_store = ctrl_wr && key[BIT_WRITE_STROBE] && arm_r
    && seq_r == SEQ_OPEN && !store_busy && !powerup_busy
    && !key[BIT_CODE_SEL] && !key[BIT_CONFIG_SEL] && !warm_rst;

  // Bus answer: one cycle after the request, dropped the cycle after
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  assign ctrl_view = {code_sel_r, config_sel_r, 2'b00, aborted_r, arm_r,
                      store_busy, read_strobe_r};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd) begin
      rdata_r <= 32'h0000_0000;
      if (hit(wb_adr_i, OFS_ACCESS_CONTROL)) begin
        rdata_r[7:0] <= ctrl_view;
      end else if (hit(wb_adr_i, OFS_CELL_POINTER)) begin
        rdata_r[7:0] <= pointer_r;
      end else if (hit(wb_adr_i, OFS_CELL_VALUE)) begin
        rdata_r[7:0] <= value_r;
      end else if (hit(wb_adr_i, OFS_EVENT_STATUS)) begin
        rdata_r[BIT_DONE_FLAG] <= done_flag_r;
        rdata_r[BIT_POWERUP_BUSY] <= powerup_busy;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // Unlock sequence; any other write in between breaks it
  always_comb begin
    seq_nxt = seq_r;
    if (warm_rst || store_busy) begin
      seq_nxt = SEQ_IDLE;
    end else if (wr) begin
      case (seq_r)
        SEQ_GOT_FIRST: begin
          if (unlock_wr && key == UNLOCK_KEY_SECOND) begin
            seq_nxt = SEQ_OPEN;
          end else if (unlock_wr && key == UNLOCK_KEY_FIRST) begin
            seq_nxt = SEQ_GOT_FIRST;
          end else begin
            seq_nxt = SEQ_IDLE;
          end
        end
        SEQ_IDLE, SEQ_OPEN: begin
          if (unlock_wr && key == UNLOCK_KEY_FIRST) begin
            seq_nxt = SEQ_GOT_FIRST;
          end else begin
            seq_nxt = SEQ_IDLE;
          end
        end
        default: seq_nxt = SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= SEQ_IDLE;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  // Control bits; arm only changes by software or a reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arm_r <= 1'b0;
      code_sel_r <= 1'b0;
      config_sel_r <= 1'b0;
    end else if (warm_rst) begin
      arm_r <= 1'b0;
    end else if (ctrl_wr) begin
      arm_r <= key[BIT_STORE_ARM];
      code_sel_r <= key[BIT_CODE_SEL];
      config_sel_r <= key[BIT_CONFIG_SEL];
    end
  end

  // Abort capture wins over a software write in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aborted_r <= 1'b0;
    end else if (warm_rst && store_busy) begin
      aborted_r <= 1'b1;
    end else if (ctrl_wr) begin
      aborted_r <= key[BIT_ABORTED];
    end
  end

  // Read strobe lives one cycle; code space reads are refused
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_strobe_r <= 1'b0;
    end else if (read_strobe_r || warm_rst) begin
      read_strobe_r <= 1'b0;
    end else if (ctrl_wr && key[BIT_READ_STROBE] && !key[BIT_CODE_SEL]) begin
      read_strobe_r <= 1'b1;
    end
  end

  // Configuration space reads leave the value untouched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      value_r <= BYTE_RESET;
    end else if (read_strobe_r && !config_sel_r) begin
      value_r <= mem_rdata;
    end else if (wr && hit(wb_adr_i, OFS_CELL_VALUE)) begin
      value_r <= key;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pointer_r <= BYTE_RESET;
    end else if (wr && hit(wb_adr_i, OFS_CELL_POINTER)) begin
      pointer_r <= key;
    end
  end

  // Latched at start so later pointer or value writes cannot alter the cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      store_addr_r <= BYTE_RESET;
      store_data_r <= BYTE_RESET;
    end else if (start_store) begin
      store_addr_r <= pointer_r;
      store_data_r <= value_r;
    end
  end

  // Done flag: set wins over a firmware clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_flag_r <= 1'b0;
    end else if (store_done) begin
      done_flag_r <= 1'b1;
    end else if (wr && hit(wb_adr_i, OFS_EVENT_STATUS) && key[BIT_DONE_FLAG]) begin
      done_flag_r <= 1'b0;
    end
  end

  // Write strobe is the busy state of the timer; only completion or a warm reset abort ends it
  dee_down_timer #(
    .WIDTH(STORE_CNT_W),
    .COUNT(STORE_CYCLES),
    .START_RUNNING(1'b0)
  ) u_store_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(start_store),
    .abort(warm_rst),
    .busy(store_busy),
    .done(store_done)
  );

  dee_down_timer #(
    .WIDTH(POWERUP_CNT_W),
    .COUNT(POWERUP_CYCLES_P),
    .START_RUNNING(1'b1)
  ) u_powerup_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(1'b0),
    .abort(1'b0),
    .busy(powerup_busy),
    .done()
  );

  // Cell written only on completion, so an aborted cycle leaves it intact
  dee_cell_array u_cells (
    .clock(clock),
    .rst_n(rst_n),
    .write_en(store_done),
    .write_index(store_addr_r),
    .write_value(store_data_r),
    .read_index(pointer_r),
    .read_value(mem_rdata)
  );

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_store_starts: assert property (start_store |=> store_busy)
    else $error("write cycle did not start");
  chk_strobe_only_hw: assert property ($fell(store_busy) |-> store_done || $past(warm_rst))
    else $error("write strobe cleared without completion");
  chk_read_one_cycle: assert property (read_strobe_r |=> !read_strobe_r)
    else $error("read strobe stayed set");
  chk_read_code_block: assert property (ctrl_wr && key[BIT_CODE_SEL] |=> !read_strobe_r)
    else $error("read strobe set with code select");
  chk_read_value: assert property (
    read_strobe_r && !config_sel_r |=> value_r == $past(mem_rdata))
    else $error("read byte not loaded");
  chk_value_hold: assert property (
    !read_strobe_r && !(wr && hit(wb_adr_i, OFS_CELL_VALUE)) |=> $stable(value_r))
    else $error("value changed without cause");
  chk_unlock_order: assert property ($rose(store_busy) |-> $past(seq_r) == SEQ_OPEN)
    else $error("write started without unlock");
  chk_arm_kept: assert property (arm_r && !warm_rst && !ctrl_wr |=> arm_r)
    else $error("arm cleared by hardware");
  chk_arm_no_abort: assert property (
    store_busy && ctrl_wr && !key[BIT_STORE_ARM] && !warm_rst
    |=> store_busy || store_done)
    else $error("clearing arm stopped the cycle");
  chk_arm_gate: assert property ($rose(store_busy) |-> $past(arm_r, 2))
    else $error("write started without prior arm");
  chk_done_flag: assert property (store_done |=> done_flag_r && !store_busy)
    else $error("done flag not set on completion");
  chk_powerup_block: assert property (powerup_busy |=> !store_busy || $past(store_busy))
    else $error("write started during power-up");
  chk_abort_flag: assert property (warm_rst && store_busy |=> aborted_r && !store_busy)
    else $error("aborted flag not set");
  chk_busy_ignore: assert property (store_busy |=> seq_r == SEQ_IDLE)
    else $error("unlock accepted during write");

  cov_store_done: cover property (start_store ##[1:300] store_done);
  cov_read: cover property (read_strobe_r ##1 !read_strobe_r);
  cov_abort: cover property (store_busy && warm_rst);
  cov_refused: cover property (ctrl_wr && key[BIT_WRITE_STROBE] && seq_r != SEQ_OPEN);
endmodule

// File: sim/dee_cpu_model.sv
// Processor core model: firmware register accesses as a Wishbone master.
// Assumes a classic Wishbone slave on the same clock; the bench watchdog ends a hung wait.
`timescale 1ns/100ps
module dee_cpu_model
  import dee_pkg::*;
(
  input wire logic clock,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h00000000;
  end

  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                     output logic [7:0] rdat);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_dat_o <= {24'h000000, dat};
    @(posedge clock);
    // No assumed latency; wait for the answer however long it takes
    while (wb_ack_i !== 1'b1) begin
      @(posedge clock);
    end
    rdat = wb_dat_i[7:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // Released lines wander so a stale value never looks live
    wb_adr_o <= ~adr;
    wb_dat_o <= ~wb_dat_o;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [7:0] d;
    bus(1'b1, adr, dat, d);
  endtask

  task automatic rd(input logic [7:0] adr, output logic [7:0] d);
    bus(1'b0, adr, 8'h00, d);
  endtask

  task automatic read_cell(input logic [7:0] ptr, output logic [7:0] val);
    wr(OFS_CELL_POINTER, ptr);
    wr(OFS_ACCESS_CONTROL, 8'h01);
    rd(OFS_CELL_VALUE, val);
  endtask

  // Nothing else on the bus between keys and strobe
  task automatic unlock_strobe(input logic [7:0] ctrl);
    wr(OFS_UNLOCK_PORT, UNLOCK_KEY_FIRST);
    wr(OFS_UNLOCK_PORT, UNLOCK_KEY_SECOND);
    wr(OFS_ACCESS_CONTROL, ctrl);
  endtask

  task automatic store_cell(input logic [7:0] ptr, input logic [7:0] val);
    wr(OFS_CELL_POINTER, ptr);
    wr(OFS_CELL_VALUE, val);
    wr(OFS_ACCESS_CONTROL, 8'h04);
    unlock_strobe(8'h06);
  endtask

  task automatic clear_done;
    wr(OFS_EVENT_STATUS, 8'h01);
  endtask
endmodule

// File: sim/data_eeprom_access_ctrl_tb.sv
// Self-checking bench for the data store access block.
// Assumes the processor model in sim/ and a shortened power-up timer.
`timescale 1ns/100ps
module data_eeprom_access_ctrl_tb
  import dee_pkg::*;
;
  logic clock, rst_n, master_clear_pin_n, watchdog_reset;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat;
  logic [7:0] mem [256];
  logic [7:0] d, p, q, v;
  logic [31:0] seed;
  int n, bad_count, check_count;

  dee_access_ctrl #(.POWERUP_CYCLES_P(40)) i_dee_access_ctrl (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .master_clear_pin_n(master_clear_pin_n),
    .watchdog_reset(watchdog_reset));
  dee_cpu_model i_dee_cpu_model (
    .clock(clock), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
    .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack));

  always #10 clock = ~clock;

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [7:0] exp_ctrl(input logic arm, input logic busy, input logic ab);
    return {4'h0, ab, arm, busy, 1'b0};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_clear(input logic [7:0] adr, input int b, output int cnt);
    logic [7:0] r;
    cnt = 0;
    do begin
      i_dee_cpu_model.rd(adr, r);
      cnt++;
    end while (r[b] !== 1'b0 && cnt < 200);
    if (r[b] !== 1'b0) begin
      bad_count++;
      $display("wrong value at %0t: bit never cleared", $time);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(20ns * 30000);
    bad_count++;
    $display("wrong value at %0t: run hung", $time);
    stop_test();
  end

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    master_clear_pin_n = 1'b1;
    watchdog_reset = 1'b0;
    seed = 32'd39462;
    bad_count = 0;
    check_count = 0;
    for (int i = 0; i < 256; i++) mem[i] = CELL_ERASED;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    i_dee_cpu_model.rd(OFS_EVENT_STATUS, d);
    check(d, 8'h02, "timer running");
    i_dee_cpu_model.rd(OFS_ACCESS_CONTROL, d);
    check(d, 8'h00, "control after reset");
    i_dee_cpu_model.store_cell(8'h10, 8'h3C);
    i_dee_cpu_model.rd(OFS_ACCESS_CONTROL, d);
    check(d, exp_ctrl(1'b1, 1'b0, 1'b0), "store in power-up");
    wait_clear(OFS_EVENT_STATUS, BIT_POWERUP_BUSY, n);
    i_dee_cpu_model.read_cell(8'h10, d);
    check(d, mem[8'h10], "cell after power-up store");
    for (int j = 0; j < 6; j++) begin
      p = xs();
      v = xs();
      i_dee_cpu_model.store_cell(p, v);
      mem[p] = v;
      if (j == 1) begin
        i_dee_cpu_model.wr(OFS_ACCESS_CONTROL, 8'h00);
        i_dee_cpu_model.rd(OFS_ACCESS_CONTROL, d);
        check(d, exp_ctrl(1'b0, 1'b1, 1'b0), "arm dropped mid-cycle");
      end
      if (j == 2) begin
        q = p ^ 8'h01;
        i_dee_cpu_model.wr(OFS_CELL_POINTER, q);
        i_dee_cpu_model.unlock_strobe(8'h06);
      end
      wait_clear(OFS_ACCESS_CONTROL, BIT_WRITE_STROBE, n);
      // Each status poll costs three clock cycles
      check({7'h00, n >= STORE_CYCLES / 3 - 8 && n <= STORE_CYCLES / 3 + 4}, 8'h01, "length");
      i_dee_cpu_model.rd(OFS_EVENT_STATUS, d);
      check(d, 8'h01, "done flag");
      i_dee_cpu_model.rd(OFS_ACCESS_CONTROL, d);
      check(d, exp_ctrl(j != 1, 1'b0, 1'b0), "control after store");
      i_dee_cpu_model.clear_done();
      i_dee_cpu_model.rd(OFS_EVENT_STATUS, d);
      check(d, 8'h00, "done flag cleared");
      i_dee_cpu_model.read_cell(p, d);
      check(d, v, "read back");
      i_dee_cpu_model.rd(OFS_CELL_VALUE, d);
      check(d, v, "value held");
      i_dee_cpu_model.rd(OFS_CELL_POINTER, d);
      check(d, p, "pointer readback");
      if (j == 2) begin
        i_dee_cpu_model.read_cell(q, d);
        check(d, mem[q], "store while busy");
      end
    end
    // Each refused start must leave the strobe at zero
    for (int k = 0; k < 4; k++) begin
      i_dee_cpu_model.wr(OFS_ACCESS_CONTROL, (k < 2) ? 8'h00 : 8'h04);
      case (k)
        0: i_dee_cpu_model.unlock_strobe(8'h02);
        1: i_dee_cpu_model.unlock_strobe(8'h06);
        2: begin
          i_dee_cpu_model.wr(OFS_UNLOCK_PORT, UNLOCK_KEY_SECOND);
          i_dee_cpu_model.wr(OFS_UNLOCK_PORT, UNLOCK_KEY_FIRST);
          i_dee_cpu_model.wr(OFS_ACCESS_CONTROL, 8'h06);
        end
        default: begin
          i_dee_cpu_model.wr(OFS_UNLOCK_PORT, UNLOCK_KEY_FIRST);
          i_dee_cpu_model.wr(OFS_CELL_VALUE, 8'h5A);
          i_dee_cpu_model.wr(OFS_UNLOCK_PORT, UNLOCK_KEY_SECOND);
          i_dee_cpu_model.wr(OFS_ACCESS_CONTROL, 8'h06);
        end
      endcase
      i_dee_cpu_model.rd(OFS_ACCESS_CONTROL, d);
      check(d & 8'h02, 8'h00, "refused start");
    end
    for (int k = 0; k < 2; k++) begin
      i_dee_cpu_model.wr(OFS_CELL_VALUE, 8'hA5);
      i_dee_cpu_model.wr(OFS_CELL_POINTER, 8'h10);
      i_dee_cpu_model.wr(OFS_ACCESS_CONTROL, (k == 0) ? 8'h81 : 8'h41);
      i_dee_cpu_model.rd(OFS_CELL_VALUE, d);
      check(d, 8'hA5, "read with select set");
    end
    for (int k = 0; k < 2; k++) begin
      p = xs();
      i_dee_cpu_model.store_cell(p, ~mem[p]);
      repeat (20) @(posedge clock);
      if (k == 0) master_clear_pin_n <= 1'b0;
      else watchdog_reset <= 1'b1;
      repeat (4) @(posedge clock);
      master_clear_pin_n <= 1'b1;
      watchdog_reset <= 1'b0;
      repeat (4) @(posedge clock);
      i_dee_cpu_model.rd(OFS_ACCESS_CONTROL, d);
      check(d, exp_ctrl(1'b0, 1'b0, 1'b1), "aborted store");
      i_dee_cpu_model.read_cell(p, d);
      check(d, mem[p], "cell after abort");
    end
    stop_test();
  end
endmodule
